// [logic/prs_ramp_safeload.sv]
// target/slew ramp engine with safeload staging and frame-gap commit
// Behaviour
// R1: shape code selects linear, dB, RC, constant-time
// R2: linear adds fixed rate-derived step in 5.23
// R3: constant-dB step taken from present slew value
// R4: RC step taken from target minus slew
// R5: constant-time step precomputed at load, then added
// R6: step count is two to code plus six
// R7: recalc trigger recomputes step, then self-clears
// R8: global mute ignores constant-time locations
// R9: target word: shape, rate, 28-bit 5.23 data
// R10: rate code 0 fastest, 15 slowest
// R11: constant-time word: shape, trigger, count, 2.14 data
// R12: host writes zero to twelve reserved bits
// R13: reset targets linear rate 5 1.0, slews 1.0
// R14: five parameter and five target staging registers
// R15: separate initiate bits commit staged words
// R16: commit done within one frame period
// R17: host keeps program at most 1531 cycles
// R18: only rewritten staging registers are committed
// R19: each slew steps at most once per frame
// R20: host writes targets only through staging
// R21: mute zeroes targets, release restores them
// R22: whole commit lands in one frame gap
// R23: stop exactly on target when step overshoots
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "prs_cfg.svh"

module prs_ramp_safeload (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`PRS_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic frame_clk,
	input wire logic slew_mute,
	output logic prm_we,
	output logic [`PRS_PRM_AW-1:0] prm_addr,
	output logic [27:0] prm_wdata,
	input wire logic [5:0] slew_rd_addr,
	output prs_pkg::prs_val_t slew_rd_data,
	output logic slew_muted
);
	import prs_pkg::*;

	// ******************************
	// storage
	// ******************************
	logic [`PRS_PRM_AW-1:0] pstg_addr_reg [`PRS_STAGES];
	logic [27:0] pstg_data_reg [`PRS_STAGES];
	logic [5:0] tstg_addr_reg [`PRS_STAGES];
	prs_tword_t tstg_data_reg [`PRS_STAGES];
	prs_tword_t tgt_mem [`PRS_ENTRIES];
	prs_val_t slew_mem [`PRS_ENTRIES];
	prs_val_t ct_step_mem [`PRS_ENTRIES];

	logic [`PRS_STAGES-1:0] pdirty_reg, pdirty_next, tdirty_reg, tdirty_next;
	logic go_prm_reg, go_prm_next, go_tgt_reg, go_tgt_next;
	logic do_prm_reg, do_prm_next, do_tgt_reg, do_tgt_next;
	prs_state_e state_reg, state_next;
	logic [5:0] idx_reg, idx_next;
	logic [31:0] rdata_reg, rdata_next;
	logic fsync1_reg, fsync2_reg, fsync3_reg;
	logic msync1_reg, msync2_reg;
	logic nz_seen_reg, nz_seen_next, muted_reg, muted_next;
	prs_val_t rd_reg;
	logic frame_tick;

	// ******************************
	// pin synchronisers
	// ******************************
	// the frame clock is a pin: two flops before use, third only for edge detect
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fsync1_reg <= 1'b0;
			fsync2_reg <= 1'b0;
			fsync3_reg <= 1'b0;
			msync1_reg <= 1'b0;
			msync2_reg <= 1'b0;
		end else begin
			fsync1_reg <= frame_clk;
			fsync2_reg <= fsync1_reg;
			fsync3_reg <= fsync2_reg;
			msync1_reg <= slew_mute;
			msync2_reg <= msync1_reg;
		end
	end
	assign frame_tick = fsync2_reg & ~fsync3_reg;

	// ******************************
	// register port decode
	// ******************************
	logic stg_hit_p, stg_hit_t, stg_is_data;
	logic [2:0] stg_sel;
	logic [`PRS_ADDR_W-1:0] p_rel, t_rel;
	always_comb begin
		p_rel = reg_addr - `PRS_PSTG_BASE;
		t_rel = reg_addr - `PRS_TSTG_BASE;
		stg_hit_p = (reg_addr >= `PRS_PSTG_BASE) && (reg_addr < `PRS_TSTG_BASE)
			&& (reg_addr[1:0] == 2'h0);
		stg_hit_t = (reg_addr >= `PRS_TSTG_BASE) && (reg_addr < `PRS_CTRL_OFF)
			&& (reg_addr[1:0] == 2'h0);
		stg_is_data = reg_addr[2];
		stg_sel = stg_hit_p ? p_rel[`PRS_STG_STRIDE_SH+2:`PRS_STG_STRIDE_SH]
			: t_rel[`PRS_STG_STRIDE_SH+2:`PRS_STG_STRIDE_SH];
	end

	// staging writes; a data write marks the slot as rewritten [R14] [R18] [R20]
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < `PRS_STAGES; i++) begin
				pstg_addr_reg[i] <= '0;
				pstg_data_reg[i] <= '0;
				tstg_addr_reg[i] <= '0;
				tstg_data_reg[i] <= '0;
			end
		end else if (reg_wr && stg_hit_p) begin
			if (stg_is_data)
				pstg_data_reg[stg_sel] <= reg_wdata[27:0];
			else
				pstg_addr_reg[stg_sel] <= reg_wdata[`PRS_PRM_AW-1:0];
		end else if (reg_wr && stg_hit_t) begin
			// high word carries the two shape bits above the 32 data bits [R9]
			if (stg_is_data) begin
				tstg_data_reg[stg_sel][31:0] <= reg_wdata;
			end else begin
				tstg_addr_reg[stg_sel] <= reg_wdata[5:0];
				tstg_data_reg[stg_sel][33:32] <= reg_wdata[`PRS_TSTG_HI_LSB+1:`PRS_TSTG_HI_LSB];
			end
		end
	end

	// ******************************
	// commit sequencer and ramp walk
	// ******************************
	logic [2:0] cidx;
	assign cidx = idx_reg[2:0];

	always_comb begin
		state_next = state_reg;
		idx_next = idx_reg;
		pdirty_next = pdirty_reg;
		tdirty_next = tdirty_reg;
		go_prm_next = go_prm_reg;
		go_tgt_next = go_tgt_reg;
		do_prm_next = do_prm_reg;
		do_tgt_next = do_tgt_reg;
		unique case (state_reg)
			PRS_IDLE: begin
				if (frame_tick) begin
					// latch requests at the frame edge so the whole set lands in one gap [R16] [R22]
					do_prm_next = go_prm_reg;
					do_tgt_next = go_tgt_reg;
					go_prm_next = 1'b0;
					go_tgt_next = 1'b0;
					idx_next = '0;
					state_next = PRS_COMMIT;
				end
			end
			PRS_COMMIT: begin
				if (do_prm_reg)
					pdirty_next[cidx] = 1'b0; // [R18]
				if (do_tgt_reg)
					tdirty_next[cidx] = 1'b0; // [R18]
				if (cidx == 3'(`PRS_STAGES - 1)) begin
					idx_next = '0;
					state_next = PRS_RAMP;
				end else begin
					idx_next = idx_reg + 6'h1;
				end
			end
			PRS_RAMP: begin
				idx_next = idx_reg + 6'h1;
				if (idx_reg == 6'(`PRS_ENTRIES - 1))
					state_next = PRS_IDLE; // one pass per frame edge [R19]
			end
		endcase
		// software sets win over the sequencer's clears
		if (reg_wr && stg_hit_p && stg_is_data)
			pdirty_next[stg_sel] = 1'b1;
		if (reg_wr && stg_hit_t && stg_is_data)
			tdirty_next[stg_sel] = 1'b1;
		if (reg_wr && reg_addr == `PRS_CTRL_OFF) begin
			go_prm_next = go_prm_reg | reg_wdata[`PRS_CTRL_GO_PRM]; // [R15]
			go_tgt_next = go_tgt_reg | reg_wdata[`PRS_CTRL_GO_TGT]; // [R15]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= PRS_IDLE;
			idx_reg <= '0;
			pdirty_reg <= '0;
			tdirty_reg <= '0;
			go_prm_reg <= 1'b0;
			go_tgt_reg <= 1'b0;
			do_prm_reg <= 1'b0;
			do_tgt_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			pdirty_reg <= pdirty_next;
			tdirty_reg <= tdirty_next;
			go_prm_reg <= go_prm_next;
			go_tgt_reg <= go_tgt_next;
			do_prm_reg <= do_prm_next;
			do_tgt_reg <= do_tgt_next;
		end
	end

	// parameter RAM write port, registered
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prm_we <= 1'b0;
			prm_addr <= '0;
			prm_wdata <= '0;
		end else begin
			prm_we <= (state_reg == PRS_COMMIT) && do_prm_reg && pdirty_reg[cidx]; // [R15] [R18]
			prm_addr <= pstg_addr_reg[cidx];
			prm_wdata <= pstg_data_reg[cidx];
		end
	end

	// ******************************
	// target commit with step precompute
	// ******************************
	prs_tword_t cw;
	logic [5:0] ca;
	logic signed [28:0] ct_tgt, ct_diff;
	logic [2:0] scode;
	logic tgt_we;
	always_comb begin
		cw = tstg_data_reg[cidx];
		ca = tstg_addr_reg[cidx];
		scode = cw[`PRS_SCODE_MSB:`PRS_SCODE_LSB]; // [R11]
		// 2.14 data lifted to 5.23; reserved low bits are dropped [R11] [R12]
		ct_tgt = 29'(signed'(cw[`PRS_CTD_MSB:`PRS_CTD_LSB])) <<< `PRS_CT_FRAC_SH;
		ct_diff = ct_tgt - 29'(slew_mem[ca]);
		tgt_we = (state_reg == PRS_COMMIT) && do_tgt_reg && tdirty_reg[cidx];
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < `PRS_ENTRIES; i++) begin
				tgt_mem[i] <= `PRS_TGT_RESET; // [R13]
				ct_step_mem[i] <= '0;
			end
		end else if (tgt_we) begin
			if (cw[`PRS_SHAPE_MSB:`PRS_SHAPE_LSB] == PRS_CT && cw[`PRS_RECALC_BIT]) begin
				// divide by 2^(code+6) as an arithmetic shift [R5] [R6] [R7]
				// four-bit shift amount: codes 2..7 would wrap in three bits
				ct_step_mem[ca] <= 28'(ct_diff >>> (4'(scode) + 4'(`PRS_CT_SHIFT_BASE)));
				tgt_mem[ca] <= {cw[33:32], 1'b0, cw[30:0]}; // trigger self-clears [R7]
			end else begin
				tgt_mem[ca] <= cw;
			end
		end
	end

	// ******************************
	// per-location update math
	// ******************************
	function automatic logic [28:0] lin_step(input logic [3:0] rate);
		// 2^13 * 10^(-(rate-5)/10), in 5.23 lsbs [R2] [R10]
		unique case (rate)
			4'h0: lin_step = 29'h0006531;
			4'h1: lin_step = 29'h0005061;
			4'h2: lin_step = 29'h0003fd9;
			4'h3: lin_step = 29'h00032b7;
			4'h4: lin_step = 29'h0002849;
			4'h5: lin_step = 29'h0002000;
			4'h6: lin_step = 29'h000196b;
			4'h7: lin_step = 29'h0001431;
			4'h8: lin_step = 29'h000100a;
			4'h9: lin_step = 29'h0000cbd;
			4'ha: lin_step = 29'h0000a1e;
			4'hb: lin_step = 29'h000080a;
			4'hc: lin_step = 29'h0000663;
			4'hd: lin_step = 29'h0000512;
			4'he: lin_step = 29'h0000407;
			4'hf: lin_step = 29'h0000333;
		endcase
	endfunction

	prs_tword_t rw;
	prs_shape_e shape;
	logic [3:0] rate;
	logic [4:0] esh;
	logic signed [28:0] r_tgt, r_slew, r_diff, r_new, r_ctstep;
	logic [28:0] mag_diff, mag_slew, step;
	prs_val_t slew_new;
	always_comb begin
		rw = tgt_mem[idx_reg];
		shape = prs_shape_e'(rw[`PRS_SHAPE_MSB:`PRS_SHAPE_LSB]); // [R1]
		rate = rw[`PRS_RATE_MSB:`PRS_RATE_LSB]; // [R10]
		esh = 5'(rate) + 5'(`PRS_EXP_SHIFT_BASE);
		r_slew = 29'(slew_mem[idx_reg]);
		r_ctstep = 29'(ct_step_mem[idx_reg]);
		if (shape == PRS_CT)
			r_tgt = 29'(signed'(rw[`PRS_CTD_MSB:`PRS_CTD_LSB])) <<< `PRS_CT_FRAC_SH;
		else if (msync2_reg)
			r_tgt = '0; // mute zeroes data, shape and rate kept [R8] [R21]
		else
			r_tgt = 29'(signed'(rw[27:0])); // [R9]
		r_diff = r_tgt - r_slew;
		mag_diff = r_diff[28] ? 29'(-r_diff) : r_diff;
		mag_slew = r_slew[28] ? 29'(-r_slew) : r_slew;
		unique case (shape)
			PRS_LIN: step = lin_step(rate); // [R2]
			PRS_CDB: step = mag_slew >> esh; // [R3]
			PRS_RC: step = mag_diff >> esh; // [R4]
			PRS_CT: step = r_ctstep[28] ? 29'(-r_ctstep) : r_ctstep; // [R5]
		endcase
		// a zero step would stall forever near zero, so force progress
		if (step == '0)
			step = 29'h1;
		if (mag_diff <= step)
			r_new = r_tgt; // land exactly, no overshoot [R23]
		else if (r_diff[28])
			r_new = r_slew - 29'(step);
		else
			r_new = r_slew + 29'(step);
		slew_new = 28'(r_new);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < `PRS_ENTRIES; i++)
				slew_mem[i] <= `PRS_ONE_5P23; // [R13]
		end else if (state_reg == PRS_RAMP) begin
			slew_mem[idx_reg] <= slew_new; // [R19]
		end
	end

	// ******************************
	// mute status and readback
	// ******************************
	// muted once a full pass sees every muteable slew at zero
	always_comb begin
		nz_seen_next = nz_seen_reg;
		muted_next = muted_reg & msync2_reg;
		if (state_reg == PRS_RAMP) begin
			if (idx_reg == '0)
				nz_seen_next = 1'b0;
			if (shape != PRS_CT && slew_new != '0)
				nz_seen_next = 1'b1;
			if (idx_reg == 6'(`PRS_ENTRIES - 1))
				muted_next = msync2_reg && !nz_seen_next;
		end
		rdata_next = '0;
		if (reg_rd) begin
			if (stg_hit_p)
				rdata_next = stg_is_data ? 32'(pstg_data_reg[stg_sel])
					: 32'(pstg_addr_reg[stg_sel]);
			else if (stg_hit_t)
				rdata_next = stg_is_data ? tstg_data_reg[stg_sel][31:0]
					: {14'h0, tstg_data_reg[stg_sel][33:32], 10'h0, tstg_addr_reg[stg_sel]};
			else if (reg_addr == `PRS_CTRL_OFF)
				rdata_next = {30'h0, go_tgt_reg, go_prm_reg};
			else if (reg_addr == `PRS_STAT_OFF)
				rdata_next = {16'h0, tdirty_reg, 2'h0, pdirty_reg, 1'b0, state_reg};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			nz_seen_reg <= 1'b0;
			muted_reg <= 1'b0;
			rdata_reg <= '0;
			rd_reg <= '0;
		end else begin
			nz_seen_reg <= nz_seen_next;
			muted_reg <= muted_next;
			rdata_reg <= rdata_next;
			rd_reg <= slew_mem[slew_rd_addr];
		end
	end

	assign reg_rdata = rdata_reg;
	assign slew_rd_data = rd_reg;
	assign slew_muted = muted_reg;
endmodule

// [common/prs_cfg.svh]
// offsets, field positions, reset values and timing counts of the ramp and safeload block
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH

// ******************************
// register map (byte addresses)
// ******************************
`define PRS_ADDR_W 8
`define PRS_PSTG_BASE 8'h00
`define PRS_TSTG_BASE 8'h28
`define PRS_STG_STRIDE_SH 3
`define PRS_CTRL_OFF 8'h50
`define PRS_STAT_OFF 8'h54

// ******************************
// field positions
// ******************************
`define PRS_CTRL_GO_PRM 0
`define PRS_CTRL_GO_TGT 1
`define PRS_TSTG_HI_LSB 16
`define PRS_SHAPE_MSB 33
`define PRS_SHAPE_LSB 32
`define PRS_RATE_MSB 31
`define PRS_RATE_LSB 28
`define PRS_RECALC_BIT 31
`define PRS_SCODE_MSB 30
`define PRS_SCODE_LSB 28
`define PRS_CTD_MSB 27
`define PRS_CTD_LSB 12

// ******************************
// sizes, reset values, timing
// ******************************
`define PRS_STAGES 5
`define PRS_ENTRIES 64
`define PRS_PRM_AW 10
`define PRS_ONE_5P23 28'h0800000
`define PRS_TGT_RESET {2'h0, 4'h5, `PRS_ONE_5P23}
`define PRS_CT_SHIFT_BASE 6
`define PRS_CT_FRAC_SH 9
`define PRS_EXP_SHIFT_BASE 4

`endif

// [common/prs_pkg.sv]
// types of the ramp and safeload block
package prs_pkg;
	typedef enum logic [2:0] {
		PRS_IDLE = 3'b001,
		PRS_COMMIT = 3'b010,
		PRS_RAMP = 3'b100
	} prs_state_e;

	typedef enum logic [1:0] {
		PRS_LIN = 2'h0,
		PRS_CDB = 2'h1,
		PRS_RC = 2'h2,
		PRS_CT = 2'h3
	} prs_shape_e;

	typedef logic [33:0] prs_tword_t;
	typedef logic signed [27:0] prs_val_t;
endpackage

// [verification/prs_props.sv]
// port checker of the ramp and safeload block
`timescale 1ns/1ps
`include "prs_cfg.svh"
module prs_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`PRS_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic frame_clk,
	input wire logic slew_mute,
	input wire logic prm_we,
	input wire logic [`PRS_PRM_AW-1:0] prm_addr,
	input wire logic [27:0] prm_wdata,
	input wire logic [5:0] slew_rd_addr,
	input wire prs_pkg::prs_val_t slew_rd_data,
	input wire logic slew_muted
);
	import prs_pkg::*;
	// ****************
	// frame age helpers
	// ****************
	logic fc_reg;
	logic fc_next;
	logic [7:0] age_reg;
	logic [7:0] age_next;
	logic [2:0] wcnt_reg;
	logic [2:0] wcnt_next;
	always_comb begin
		fc_next = frame_clk;
		age_next = age_reg + ((age_reg != 8'hff) ? 8'h1 : 8'h0);
		wcnt_next = wcnt_reg + (prm_we ? 3'h1 : 3'h0);
		if (frame_clk && !fc_reg) begin
			age_next = 8'h0;
			wcnt_next = 3'h0;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fc_reg <= 1'b0;
			age_reg <= 8'h0;
			wcnt_reg <= 3'h0;
		end else begin
			fc_reg <= fc_next;
			age_reg <= age_next;
			wcnt_reg <= wcnt_next;
		end
	end
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence fr_rise;
		frame_clk && !fc_reg;
	endsequence
	sequence mute_off;
		!slew_mute [*8];
	endsequence
	sequence go_then_read;
		reg_wr && reg_addr == `PRS_CTRL_OFF && reg_wdata[1:0] == 2'h3
		##2 reg_rd && reg_addr == `PRS_CTRL_OFF;
	endsequence
	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not zero outside a read");
	AST_STAT_HOT: assert property (reg_rd && reg_addr == `PRS_STAT_OFF |=>
		$onehot(reg_rdata[2:0])) else $error("state field not one-hot");
	AST_GO_PEND: assert property (go_then_read |=> reg_rdata[1:0] == 2'h3)
		else $error("initiate bits not pending");
	AST_COMMIT_WAIT: assert property (fr_rise |=> !prm_we [*3])
		else $error("parameter write before the frame tick");
	AST_PRM_IN_GAP: assert property (prm_we |-> age_reg inside {[3:12]})
		else $error("parameter write outside the frame gap");
	AST_PRM_MAX5: assert property (prm_we |-> wcnt_reg < 3'h5)
		else $error("more than five words in one commit");
	AST_SLEW_ONCE: assert property ($past(slew_rd_addr) == $past(slew_rd_addr, 2)
		&& slew_rd_data != $past(slew_rd_data) |-> age_reg <= 8'd80)
		else $error("slew moved outside the ramp pass");
	AST_MUTE_OFF: assert property (mute_off |-> !slew_muted)
		else $error("muted flag without mute");
endmodule

// [verification/prs_host.sv]
// host model driving the control port of the ramp and safeload block
`timescale 1ns/1ps
`include "prs_cfg.svh"
module prs_host (
	input wire logic clk,
	output logic [`PRS_ADDR_W-1:0] reg_addr,
	output logic [31:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [31:0] reg_rdata
);
	// ****************
	// bus cycles
	// ****************
	initial begin
		reg_addr = 8'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// released lines carry the inverse so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask
	task automatic prm(input int i, input logic [9:0] a, input logic [27:0] d);
		wr(8'(8 * i), {22'h0, a});
		wr(8'(8 * i + 4), {4'h0, d});
	endtask
	// targets only ever go through the staging slots, address word first
	task automatic tgt(input int i, input logic [5:0] loc, input logic [33:0] w);
		wr(`PRS_TSTG_BASE + 8'(8 * i), {14'h0, w[33:32], 10'h0, loc});
		wr(`PRS_TSTG_BASE + 8'(8 * i + 4), w[31:0]);
	endtask
	// new constant-time target: trigger set, reserved bits zero
	function automatic logic [33:0] ct(input logic [2:0] code, input logic [15:0] d);
		return {2'h3, 1'b1, code, d, 12'h0};
	endfunction
endmodule

// [verification/tb.sv]
// top testbench of the ramp and safeload block
`timescale 1ns/1ps
`include "prs_cfg.svh"
`define CHK(g, e) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("wrong value t=%0t got %h exp %h", $time, (g), (e)); \
	end \
end
module tb;
	import prs_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic frame_clk = 1'b0;
	logic slew_mute = 1'b0;
	logic [5:0] slew_rd_addr = 6'h0;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rdv;
	logic reg_wr, reg_rd, prm_we, slew_muted;
	logic [9:0] prm_addr;
	logic [27:0] prm_wdata;
	prs_val_t slew_rd_data;
	logic [37:0] seen[$];
	int error_cnt = 0;
	int num_checks = 0;
	// ****************
	// harness
	// ****************
	always #5 clk = ~clk;
	prs_ramp_safeload dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.frame_clk, .slew_mute, .prm_we, .prm_addr, .prm_wdata, .slew_rd_addr, .slew_rd_data,
		.slew_muted);
	prs_host host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	always @(posedge clk) begin
		if (prm_we === 1'b1) begin
			seen.push_back({prm_addr, prm_wdata});
		end
	end
	task automatic give_verdict();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// period 101 cycles, well above the 70 the commit and ramp pass need
	task automatic frame();
		@(posedge clk);
		frame_clk <= 1'b1;
		repeat (40) @(posedge clk);
		frame_clk <= 1'b0;
		repeat (60) @(posedge clk);
	endtask
	task automatic slew(input logic [5:0] loc, input prs_val_t e);
		@(posedge clk);
		slew_rd_addr <= loc;
		repeat (2) @(posedge clk);
		#1 `CHK(slew_rd_data, e)
	endtask
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end
	// ****************
	// scenarios
	// ****************
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 4; i++) slew(6'(i * 21), 28'h0800000);
		host.rd(`PRS_STAT_OFF, rdv);
		`CHK(rdv, 32'h1)
		host.rd(8'h60, rdv);
		`CHK(rdv, 32'h0)
		for (int i = 0; i < 5; i++) host.prm(i, 10'(10'h100 + i), 28'(28'habc000 + i));
		host.rd(`PRS_STAT_OFF, rdv);
		`CHK(rdv[8:4], 5'h1f)
		host.wr(`PRS_CTRL_OFF, 32'h1);
		frame();
		`CHK(seen.size(), 5)
		for (int i = 0; i < 5; i++) `CHK(seen[i], {10'(10'h100 + i), 28'(28'habc000 + i)})
		seen.delete();
		// second round rewrites slot 1 whole and only the data of slot 3
		host.prm(1, 10'h3ff, 28'hfffffff);
		host.wr(8'h1c, 32'h0123456);
		host.wr(`PRS_CTRL_OFF, 32'h3);
		host.rd(`PRS_CTRL_OFF, rdv);
		`CHK(rdv[1:0], 2'h3)
		frame();
		`CHK(seen.size(), 2)
		`CHK(seen[0], {10'h3ff, 28'hfffffff})
		`CHK(seen[1], {10'h103, 28'h0123456})
		host.rd(`PRS_STAT_OFF, rdv);
		`CHK(rdv[15:0], 16'h1)
		host.tgt(0, 6'h1, host.ct(3'h0, 16'h2000));
		host.tgt(1, 6'h3, host.ct(3'h2, 16'h0));
		host.tgt(2, 6'h2, {2'h2, 4'h0, 28'h0});
		host.tgt(3, 6'h6, {2'h1, 4'h0, 28'h0});
		host.tgt(4, 6'h7, {2'h0, 4'h5, 28'h0});
		host.rd(`PRS_STAT_OFF, rdv);
		`CHK(rdv[15:11], 5'h1f)
		@(posedge clk) slew_mute <= 1'b1;
		host.wr(`PRS_CTRL_OFF, 32'h2);
		frame();
		slew(6'h1, 28'h07f0000);
		slew(6'h3, 28'h07f8000);
		slew(6'h2, 28'h0780000);
		slew(6'h6, 28'h0780000);
		slew(6'h7, 28'h07fe000);
		slew(6'h4, 28'h07fe000);
		`CHK(slew_muted, 1'b0)
		@(posedge clk) slew_mute <= 1'b0;
		repeat (63) frame();
		slew(6'h1, 28'h0400000);
		slew(6'h3, 28'h0600000);
		slew(6'h7, 28'h0780000);
		slew(6'h4, 28'h0800000);
		give_verdict();
	end
endmodule
bind prs_ramp_safeload prs_props chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .frame_clk, .slew_mute, .prm_we, .prm_addr, .prm_wdata, .slew_rd_addr,
	.slew_rd_data, .slew_muted);
